// ---- hdl/b1sfr_pkg.sv ----
package b1sfr_pkg;

  // Data memory address: 9 bits cover all four banks.
  localparam int ADDR_W = 9;
  localparam int NREG   = 23;

  typedef logic [ADDR_W-1:0] b1sfr_addr_t;
  typedef logic [7:0]        b1sfr_byte_t;

  // Register indices as printed; the APB byte address is four times the index.
  localparam b1sfr_addr_t IDX_WINDOW      = 9'h080;
  localparam b1sfr_addr_t IDX_PRESCALE    = 9'h081;
  localparam b1sfr_addr_t IDX_PC_LOW      = 9'h082;
  localparam b1sfr_addr_t IDX_CORE_FLAGS  = 9'h083;
  localparam b1sfr_addr_t IDX_POINTER     = 9'h084;
  localparam b1sfr_addr_t IDX_DIR_A       = 9'h085;
  localparam b1sfr_addr_t IDX_DIR_B       = 9'h086;
  localparam b1sfr_addr_t IDX_DIR_C       = 9'h087;
  localparam b1sfr_addr_t IDX_DIR_D       = 9'h088;
  localparam b1sfr_addr_t IDX_DIR_E       = 9'h089;
  localparam b1sfr_addr_t IDX_PC_LATCH    = 9'h08a;
  localparam b1sfr_addr_t IDX_IRQ_CTRL    = 9'h08b;
  localparam b1sfr_addr_t IDX_PERIPHERAL_IRQ_ENABLE_1        = 9'h08c;
  localparam b1sfr_addr_t IDX_PERIPHERAL_IRQ_ENABLE_2        = 9'h08d;
  localparam b1sfr_addr_t IDX_PWR_FLAGS   = 9'h08e;
  localparam b1sfr_addr_t IDX_SER_CTRL2   = 9'h091;
  localparam b1sfr_addr_t IDX_T2_PERIOD   = 9'h092;
  localparam b1sfr_addr_t IDX_SER_ADDR    = 9'h093;
  localparam b1sfr_addr_t IDX_SER_FLAGS   = 9'h094;
  localparam b1sfr_addr_t IDX_TX_CTRL     = 9'h098;
  localparam b1sfr_addr_t IDX_BAUD        = 9'h099;
  localparam b1sfr_addr_t IDX_CMP_CTRL    = 9'h09c;
  localparam b1sfr_addr_t IDX_CMP_REF     = 9'h09d;
  localparam b1sfr_addr_t IDX_ADC_LOW     = 9'h09e;
  localparam b1sfr_addr_t IDX_ADC_CFG1    = 9'h09f;
  localparam b1sfr_addr_t IDX_NV_ADDR_HI  = 9'h10f;

  // Entry positions in the storage table.
  localparam int E_PRESCALE = 0;
  localparam int E_FLAGS    = 1;
  localparam int E_POINTER  = 2;
  localparam int E_DIR_D    = 6;
  localparam int E_DIR_E    = 7;
  localparam int E_PC_LATCH = 8;
  localparam int E_SER_FLAG = 16;
  localparam int E_TX_CTRL  = 17;
  localparam int E_CMP_CTRL = 19;
  localparam int E_NV_HI    = 22;

  localparam b1sfr_addr_t REG_IDX [NREG] = '{
    IDX_PRESCALE, IDX_CORE_FLAGS, IDX_POINTER, IDX_DIR_A, IDX_DIR_B, IDX_DIR_C,
    IDX_DIR_D, IDX_DIR_E, IDX_PC_LATCH, IDX_IRQ_CTRL, IDX_PERIPHERAL_IRQ_ENABLE_1, IDX_PERIPHERAL_IRQ_ENABLE_2,
    IDX_PWR_FLAGS, IDX_SER_CTRL2, IDX_T2_PERIOD, IDX_SER_ADDR, IDX_SER_FLAGS,
    IDX_TX_CTRL, IDX_BAUD, IDX_CMP_CTRL, IDX_CMP_REF, IDX_ADC_CFG1, IDX_NV_ADDR_HI};

  localparam b1sfr_byte_t REG_RESET [NREG] = '{
    8'hff, 8'h18, 8'h00, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h07, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00,
    8'h00};

  // Bits software may write.
  localparam b1sfr_byte_t REG_WMASK [NREG] = '{
    8'hff, 8'he7, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h17, 8'h1f, 8'hff, 8'hff,
    8'h59, 8'h03, 8'hff, 8'hff, 8'hff, 8'hc0, 8'hf5, 8'hff, 8'h3f, 8'hef, 8'hcf,
    8'h1f};

  // Stored bits that read back; differs from the write mask where a bit is read-only.
  localparam b1sfr_byte_t REG_RMASK [NREG] = '{
    8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h17, 8'h1f, 8'hff, 8'hff,
    8'h59, 8'h03, 8'hff, 8'hff, 8'hff, 8'hc0, 8'hf5, 8'hff, 8'h3f, 8'hef, 8'hcf,
    8'h1f};

  // Bits whose value comes live from the peripheral side.
  localparam b1sfr_byte_t REG_HWMASK [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he0, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h02, 8'h00, 8'hc0, 8'h00, 8'h00,
    8'h00};

  // Entries seen at the same offset in every bank.
  localparam logic [NREG-1:0] REG_MIRROR = 23'h000306;

  // Field positions.
  localparam int FLAG_IRP        = 7;
  localparam int FLAG_BANK_HI    = 6;
  localparam int FLAG_BANK_LO    = 5;
  localparam int DIRE_OVERFLOW   = 5;
  localparam int NV_HI_LARGE_BIT = 4;
  localparam int PC_W            = 13;
  localparam int PC_LATCH_W      = 5;
  localparam int BANK_OFS_W      = 7;
  localparam int TX_IDLE_BIT     = 1;

  typedef struct packed {
    logic       pc_step;
    logic       in_buf_full;
    logic       out_buf_full;
    logic       in_buf_overflow;
    logic [5:0] ser_status;
    logic       tx_idle;
    logic [1:0] cmp_out;
    logic [7:0] adc_low;
  } b1sfr_hw_t;

endpackage : b1sfr_pkg

// ---- hdl/b1sfr_reg8.sv ----
`timescale 1ns/1ps
module b1sfr_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Write port
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] wmask,
  // Stored value
  output logic      [7:0] q
);

  // Masked bits keep their value, so read-only and absent bits never move.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RESET_VAL;
    end else if (we) begin
      q <= (q & ~wmask) | (wdata & wmask);
    end
  end

endmodule : b1sfr_reg8

// ---- hdl/b1sfr_bank.sv ----
`timescale 1ns/1ps
module b1sfr_bank #(
  parameter bit HAS_PORT_DE   = 1'b1,
  parameter bit LARGE_PROGRAM = 1'b1
) (
  // Clock and reset
  input  wire logic                                         pclk,
  input  wire logic                                         presetn,
  // APB slave
  input  wire logic                                         psel,
  input  wire logic                                         penable,
  input  wire logic                                         pwrite,
  input  wire logic [10:0]                                  paddr,
  input  wire logic [31:0]                                  pwdata,
  input  wire logic [3:0]                                   pstrb,
  output logic      [31:0]                                  prdata,
  output logic                                              pready,
  output logic                                              pslverr,
  // Peripheral and core side
  input  wire b1sfr_pkg::b1sfr_hw_t                         hw,
  output logic      [b1sfr_pkg::NREG-1:0][7:0]              reg_value,
  output logic      [b1sfr_pkg::PC_W-1:0]                   pc,
  output logic                                              dir_e_overflow
);

  logic [7:0]                     q        [b1sfr_pkg::NREG];
  logic [7:0]                     wm_eff   [b1sfr_pkg::NREG];
  logic [7:0]                     rm_eff   [b1sfr_pkg::NREG];
  logic [7:0]                     hw_val   [b1sfr_pkg::NREG];
  logic [b1sfr_pkg::NREG-1:0]     hit;
  logic [b1sfr_pkg::NREG-1:0]     we;
  logic [7:0]                     rdata;
  logic [7:0]                     wbyte;
  logic [b1sfr_pkg::PC_W-1:0]     pc_r;
  logic [b1sfr_pkg::PC_W-1:0]     pc_nxt;
  logic                           pready_r;
  logic [31:0]                    prdata_r;
  logic                           ibov_r;
  logic                           access;
  logic                           wr_fire;
  b1sfr_pkg::b1sfr_addr_t         bus_addr;
  b1sfr_pkg::b1sfr_addr_t         ind_addr;
  b1sfr_pkg::b1sfr_addr_t         tgt_addr;
  logic                           via_window;
  logic                           tgt_null;
  logic                           tgt_pc_low;
  logic                           tgt_adc_low;

  // Only the low bank offset matters for mirrored locations.
  function automatic logic same_ofs(input b1sfr_pkg::b1sfr_addr_t a,
                                    input b1sfr_pkg::b1sfr_addr_t b);
    same_ofs = (a[b1sfr_pkg::BANK_OFS_W-1:0] == b[b1sfr_pkg::BANK_OFS_W-1:0]);
  endfunction : same_ofs

  assign bus_addr = paddr[10:2];
  assign ind_addr = {q[b1sfr_pkg::E_FLAGS][b1sfr_pkg::FLAG_IRP], q[b1sfr_pkg::E_POINTER]};
  assign wbyte    = pwdata[7:0];

  assign via_window = same_ofs(bus_addr, b1sfr_pkg::IDX_WINDOW);
  assign tgt_addr   = via_window ? ind_addr : bus_addr;
  // Pointing the window at itself reaches nothing, so it cannot recurse.
  assign tgt_null   = via_window && same_ofs(ind_addr, b1sfr_pkg::IDX_WINDOW);
  assign tgt_pc_low  = !tgt_null && same_ofs(tgt_addr, b1sfr_pkg::IDX_PC_LOW);
  assign tgt_adc_low = !tgt_null && (tgt_addr == b1sfr_pkg::IDX_ADC_LOW);

  // The completion edge is the one where pready is already high.
  assign access  = psel && penable;
  assign wr_fire = access && pwrite && pready_r && pstrb[0];

  genvar gi;
  generate
    for (gi = 0; gi < b1sfr_pkg::NREG; gi++) begin : g_entry
      localparam bit IS_DE = (gi == b1sfr_pkg::E_DIR_D) || (gi == b1sfr_pkg::E_DIR_E);
      logic [7:0] gate;

      if (IS_DE) begin : g_de
        // port D/E direction absent on small variant
        assign gate = HAS_PORT_DE ? 8'hff : 8'h00;
      end else if (gi == b1sfr_pkg::E_NV_HI) begin : g_nv
        assign gate = LARGE_PROGRAM ? 8'hff : ~(8'h01 << b1sfr_pkg::NV_HI_LARGE_BIT);
      end else begin : g_plain
        assign gate = 8'hff;
      end

      // absent bits neither stored nor read
      assign wm_eff[gi] = b1sfr_pkg::REG_WMASK[gi] & gate;
      assign rm_eff[gi] = b1sfr_pkg::REG_RMASK[gi] & gate;

      assign hit[gi] = !tgt_null && (b1sfr_pkg::REG_MIRROR[gi]
                       ? same_ofs(tgt_addr, b1sfr_pkg::REG_IDX[gi])
                       : (tgt_addr == b1sfr_pkg::REG_IDX[gi]));
      assign we[gi]  = wr_fire && hit[gi];

      b1sfr_reg8 #(
        .RESET_VAL (b1sfr_pkg::REG_RESET[gi])
      ) u_reg (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (we[gi]),
        .wdata   (wbyte),
        .wmask   (wm_eff[gi]),
        .q       (q[gi])
      );

      assign reg_value[gi] = q[gi];
    end
  endgenerate

  // Live peripheral bits, placed at their field positions.
  always_comb begin
    for (int i = 0; i < b1sfr_pkg::NREG; i++) begin
      hw_val[i] = 8'h00;
    end
    hw_val[b1sfr_pkg::E_DIR_E]    = {hw.in_buf_full, hw.out_buf_full, ibov_r, 5'h00};
    hw_val[b1sfr_pkg::E_SER_FLAG] = {2'h0, hw.ser_status};
    hw_val[b1sfr_pkg::E_TX_CTRL]  = {6'h00, hw.tx_idle, 1'b0};
    hw_val[b1sfr_pkg::E_CMP_CTRL] = {hw.cmp_out, 6'h00};
    if (!HAS_PORT_DE) begin
      hw_val[b1sfr_pkg::E_DIR_E] = 8'h00;
    end
  end

  always_comb begin
    rdata = 8'h00;
    for (int i = 0; i < b1sfr_pkg::NREG; i++) begin
      if (hit[i]) begin
        rdata = rdata | (q[i] & rm_eff[i])
                      | (hw_val[i] & b1sfr_pkg::REG_HWMASK[i]);
      end
    end
    // only the low program counter byte is mapped
    if (tgt_pc_low) begin
      rdata = pc_r[7:0];
    end
    if (tgt_adc_low) begin
      rdata = hw.adc_low;
    end
  end

  // APB answer: one wait state, read data captured with pready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= access && !pready_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (access && !pready_r && !pwrite) begin
      prdata_r <= {24'h00_0000, rdata};
    end
  end

  // writing the low byte loads the upper bits from the latch
  always_comb begin
    pc_nxt = pc_r;
    if (hw.pc_step) begin
      pc_nxt = pc_r + 13'h0001;
    end
    if (wr_fire && tgt_pc_low) begin
      pc_nxt = {q[b1sfr_pkg::E_PC_LATCH][b1sfr_pkg::PC_LATCH_W-1:0], wbyte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= 13'h0000;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // Overflow is sticky; a hardware set in the clearing cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ibov_r <= 1'b0;
    end else if (HAS_PORT_DE && hw.in_buf_overflow) begin
      ibov_r <= 1'b1;
    end else if (we[b1sfr_pkg::E_DIR_E] && !wbyte[b1sfr_pkg::DIRE_OVERFLOW]) begin
      ibov_r <= 1'b0;
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = 1'b0;
  assign pc             = pc_r;
  assign dir_e_overflow = ibov_r;

endmodule : b1sfr_bank

// ---- testbench/b1sfr_bank_properties.sv ----
`timescale 1ns/1ps
module b1sfr_bank_properties #(
  parameter bit HAS_PORT_DE   = 1'b1,
  parameter bit LARGE_PROGRAM = 1'b1
) (
  // Clock and reset
  input wire logic                                   pclk,
  input wire logic                                   presetn,
  // APB
  input wire logic                                   psel,
  input wire logic                                   penable,
  input wire logic                                   pwrite,
  input wire logic [10:0]                            paddr,
  input wire logic [31:0]                            pwdata,
  input wire logic [3:0]                             pstrb,
  input wire logic [31:0]                            prdata,
  input wire logic                                   pready,
  input wire logic                                   pslverr,
  // Core side
  input wire b1sfr_pkg::b1sfr_hw_t                   hw,
  input wire logic [b1sfr_pkg::NREG-1:0][7:0]        reg_value,
  input wire logic [b1sfr_pkg::PC_W-1:0]             pc,
  input wire logic                                   dir_e_overflow
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic done = psel && penable && pready;
  wire logic pcl_wr = done && pwrite && pstrb[0] && paddr[8:2] == 7'h02;
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  chk_one_wait: assert property (s_setup |=> s_answer) else $error("ready late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  chk_no_error: assert property (!pslverr) else $error("slave error raised");
  chk_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("upper data set");
  chk_hole_zero: assert property (done && !pwrite && paddr[10:2] inside
    {9'h08f, 9'h090, 9'h095, 9'h096, 9'h097, 9'h09a, 9'h09b} |-> prdata[7:0] == 8'h00)
    else $error("hole reads nonzero");
  chk_pc_load: assert property (pcl_wr |=> pc ==
    {$past(reg_value[b1sfr_pkg::E_PC_LATCH][4:0]), $past(pwdata[7:0])}) else $error("pc load");
  chk_latch_only: assert property (done && pwrite && paddr[8:2] == 7'h0a && !hw.pc_step
    |=> $stable(pc)) else $error("latch drove pc");
  chk_pc_step: assert property (hw.pc_step && !pcl_wr |=> pc == $past(pc) + 13'h1)
    else $error("pc step");
  chk_latch_width: assert property (reg_value[b1sfr_pkg::E_PC_LATCH][7:5] == 3'h0)
    else $error("latch too wide");
  chk_reset_state: assert property (!$past(presetn) |-> pc == 13'h0 && !pready
    && reg_value[b1sfr_pkg::E_PRESCALE] == 8'hff) else $error("reset state");
  chk_small_de: assert property (!HAS_PORT_DE && done && !pwrite && paddr[10:2] inside
    {9'h088, 9'h089} |-> prdata[7:0] == 8'h00) else $error("port D/E reads nonzero");
  chk_nv_bit4: assert property (!LARGE_PROGRAM && done && !pwrite && paddr[10:2] == 9'h10f
    |-> !prdata[4]) else $error("address-high bit 4 set");
endmodule : b1sfr_bank_properties

bind b1sfr_bank b1sfr_bank_properties #(.HAS_PORT_DE(HAS_PORT_DE),
  .LARGE_PROGRAM(LARGE_PROGRAM)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw(hw), .reg_value(reg_value),
  .pc(pc), .dir_e_overflow(dir_e_overflow));

// ---- testbench/test_b1sfr_bank.sv ----
`timescale 1ns/1ps
module test_b1sfr_bank;
  typedef struct packed {
    logic       we;
    logic [8:0] wa;
    logic [7:0] wd;
    logic [8:0] ra;
    logic [7:0] ex;
  } b1sfr_row_t;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [10:0]           paddr;
  logic [31:0]           pwdata, prdata;
  logic [3:0]            pstrb;
  b1sfr_pkg::b1sfr_hw_t  hw;
  logic [12:0]           pc;
  logic [b1sfr_pkg::NREG-1:0][7:0] regv;
  logic                  ovf;
  logic [31:0]           prdata_s;
  int                    failures, comparisons;
  logic [7:0]            q;
  // Reset reads first, then write and read back; holes and read-only bits must not stick.
  // The parallel port enable bit is always written as zero, as software must keep it.
  b1sfr_row_t rows [25] = '{
    '{1'b0, 9'h081, 8'h00, 9'h081, 8'hff}, '{1'b0, 9'h085, 8'h00, 9'h085, 8'h3f},
    '{1'b0, 9'h086, 8'h00, 9'h086, 8'hff}, '{1'b0, 9'h089, 8'h00, 9'h089, 8'h07},
    '{1'b0, 9'h092, 8'h00, 9'h092, 8'hff}, '{1'b0, 9'h098, 8'h00, 9'h098, 8'h02},
    '{1'b0, 9'h09c, 8'h00, 9'h09c, 8'h07}, '{1'b0, 9'h08a, 8'h00, 9'h08a, 8'h00},
    '{1'b0, 9'h08c, 8'h00, 9'h08c, 8'h00}, '{1'b1, 9'h081, 8'h5a, 9'h081, 8'h5a},
    '{1'b1, 9'h085, 8'hff, 9'h085, 8'h3f}, '{1'b1, 9'h08a, 8'hff, 9'h08a, 8'h1f},
    '{1'b1, 9'h08d, 8'hff, 9'h08d, 8'h59}, '{1'b1, 9'h09d, 8'hff, 9'h09d, 8'hef},
    '{1'b1, 9'h09f, 8'hff, 9'h09f, 8'hcf}, '{1'b1, 9'h08f, 8'hff, 9'h08f, 8'h00},
    '{1'b1, 9'h10f, 8'hff, 9'h10f, 8'h1f}, '{1'b1, 9'h184, 8'h33, 9'h084, 8'h33},
    '{1'b1, 9'h09e, 8'hff, 9'h09e, 8'ha5}, '{1'b1, 9'h094, 8'hff, 9'h094, 8'hc0},
    '{1'b1, 9'h098, 8'hff, 9'h098, 8'hf7}, '{1'b1, 9'h084, 8'h81, 9'h080, 8'h5a},
    '{1'b1, 9'h080, 8'h3c, 9'h081, 8'h3c}, '{1'b1, 9'h08c, 8'h7f, 9'h08c, 8'h7f},
    '{1'b1, 9'h184, 8'h80, 9'h100, 8'h00}};

  b1sfr_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hw(hw), .reg_value(regv), .pc(pc),
    .dir_e_overflow(ovf));

  // Small variant on the same bus: port D/E and address-high bit 4 absent.
  b1sfr_bank #(.HAS_PORT_DE(1'b0), .LARGE_PROGRAM(1'b0)) DUT_small (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_s), .pready(), .pslverr(), .hw(hw),
    .reg_value(), .pc(), .dir_e_overflow());

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [8:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("mismatch at %0t: no ready", $time);
      final_report();
    end else begin
      r = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb

  initial begin
    {psel, penable, pwrite, paddr, pwdata, failures, comparisons} = '0;
    pstrb = 4'hf;
    presetn = 1'b0;
    hw = '0;
    hw.tx_idle = 1'b1;
    hw.adc_low = 8'ha5;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      if (rows[i].we) apb(1'b1, rows[i].wa, rows[i].wd, q);
      apb(1'b0, rows[i].ra, 8'h00, q);
      check({8'h00, q}, {8'h00, rows[i].ex});
    end
    $display("test register rows done");
    apb(1'b1, 9'h08a, 8'h0a, q);
    check({3'h0, pc}, 16'h0000);
    check({8'h00, regv[b1sfr_pkg::E_PC_LATCH]}, 16'h000a);
    apb(1'b1, 9'h182, 8'h34, q);
    check({3'h0, pc}, 16'h0a34);
    hw.pc_step <= 1'b1;
    @(posedge pclk);
    hw.pc_step <= 1'b0;
    @(posedge pclk);
    check({3'h0, pc}, 16'h0a35);
    apb(1'b1, 9'h08a, 8'h03, q);
    check({3'h0, pc}, 16'h0a35);
    apb(1'b0, 9'h082, 8'h00, q);
    check({8'h00, q}, 16'h0035);
    apb(1'b0, 9'h08a, 8'h00, q);
    check({8'h00, q}, 16'h0003);
    $display("test program counter done");
    // Fields in struct order: step, in full, out full, overflow, serial, idle, compare, result.
    hw <= {1'b0, 1'b1, 1'b1, 1'b1, 6'h2a, 1'b1, 2'h3, 8'ha5};
    @(posedge pclk);
    hw.in_buf_overflow <= 1'b0;
    @(posedge pclk);
    check({15'h0000, ovf}, 16'h0001);
    apb(1'b0, 9'h089, 8'h00, q);
    check({8'h00, q}, 16'h00e7);
    check({8'h00, prdata_s[7:0]}, 16'h0000);
    apb(1'b0, 9'h094, 8'h00, q);
    check({8'h00, q}, 16'h00ea);
    apb(1'b0, 9'h09c, 8'h00, q);
    check({8'h00, q}, 16'h00c7);
    apb(1'b1, 9'h089, 8'h07, q);
    check({15'h0000, ovf}, 16'h0000);
    apb(1'b1, 9'h088, 8'h5c, q);
    apb(1'b0, 9'h088, 8'h00, q);
    check({8'h00, q}, 16'h005c);
    check({8'h00, prdata_s[7:0]}, 16'h0000);
    apb(1'b0, 9'h10f, 8'h00, q);
    check({8'h00, prdata_s[7:0]}, 16'h000f);
    $display("test flags and variants done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({3'h0, pc}, 16'h0000);
    apb(1'b0, 9'h081, 8'h00, q);
    check({8'h00, q}, 16'h00ff);
    $display("test second reset done");
    final_report();
  end
endmodule : test_b1sfr_bank
